// *** core/chrc_top.v ***
// halt release controller with ahb-lite register slave
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "chrc_map.vh"
module chrc_top #(
  parameter NSRC     = 4,
  parameter TICK_DIV = 32'd1000000
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg  [31:0]      hrdata,
  output reg              hreadyout,
  output reg              hresp,
  input  wire [3:0]       key_input_port,
  input  wire             watchdog_stack_reset,
  input  wire             ce_reset,
  input  wire             instr_done,
  input  wire             global_irq_on,
  input  wire             return_from_service,
  input  wire [NSRC-1:0]  source_request_flag,
  output reg              cpu_clk_en,
  output reg              periph_clk_en,
  output reg              serial_master_run,
  output reg              irq_vector_req,
  output reg  [NSRC-1:0]  irq_ack_onehot,
  output reg              tick_carry_flag,
  output reg  [3:0]       key_pulldown_en,
  output reg  [3:0]       key_dir_out,
  output reg              irq
);
  localparam ST_RUN  = 3'b001;
  localparam ST_HALT = 3'b010;
  localparam ST_SERV = 3'b100;
  // tick counts derived from the clock rate
  localparam [31:0] T0 = `CHRC_CLK_HZ / 1000 * `CHRC_TICK_MS_0;
  localparam [31:0] T1 = `CHRC_CLK_HZ / 1000 * `CHRC_TICK_MS_1;
  localparam [31:0] T2 = `CHRC_CLK_HZ / 1000 * `CHRC_TICK_MS_2;
  localparam [31:0] T3 = `CHRC_CLK_HZ / 1000 * `CHRC_TICK_MS_3;

  reg [2:0]      state_r;
  reg [3:0]      mask_r;
  reg [3:0]      adsel_r;
  reg [1:0]      rate_r;
  reg [NSRC-1:0] enable_r;
  reg [NSRC-1:0] req_r;
  reg [NSRC-1:0] clr_pend_r;
  reg [2:0]      ev_stat_r;
  reg [2:0]      ev_mask_r;
  reg            serial_slave_r;
  reg [31:0]     tick_cnt_r;
  reg            ap_valid_r;
  reg            ap_write_r;
  reg [7:0]      ap_addr_r;
  reg [2:0]      state_nxt;
  reg [3:0]      mask_nxt;
  reg            cpu_en_nxt;
  reg            ser_run_nxt;
  reg            vec_nxt;
  reg [NSRC-1:0] ack_nxt;
  reg [31:0]     rd_nxt;

  wire [3:0]      key_sync;
  wire [NSRC-1:0] pending = req_r & enable_r;
  wire            key_high = |(key_sync & ~adsel_r & ~key_dir_out);
  wire            sys_rst = watchdog_stack_reset | ce_reset;
  wire            wake_port = mask_r[`CHRC_H_PORT] & key_high;
  wire            wake_tick = mask_r[`CHRC_H_TICK] & tick_carry_flag;
  wire            wake_irq  = mask_r[`CHRC_H_IRQ] & (|pending);
  wire            wake = wake_port | wake_tick | wake_irq;
  wire            wr_en = ap_valid_r & ap_write_r;
  reg  [31:0]     tick_end;
  reg  [NSRC-1:0] top_pri;
  integer         i;

  // per-register write strobes, valid in the data phase; rd_req is the read request of the address phase
  wire            rd_req    = hready & hsel & htrans[1] & ~hwrite;
  wire            wr_tick   = wr_en & (ap_addr_r == `CHRC_OFS_TICK);
  wire            wr_src    = wr_en & (ap_addr_r == `CHRC_OFS_SOURCE);
  wire            wr_halt   = wr_en & (ap_addr_r == `CHRC_OFS_HALTCMD);
  wire            wr_evst   = wr_en & (ap_addr_r == `CHRC_OFS_IRQ_STAT);
  wire            tick_wrap = (tick_cnt_r >= tick_end - 32'd1);
  wire            halt_woke = (state_r == ST_HALT) & wake & ~sys_rst;
  wire [NSRC-1:0] req_clr   = instr_done ? clr_pend_r : {NSRC{1'b0}};
  wire [2:0]      ev_set    = {sys_rst, tick_wrap, halt_woke};
  wire [2:0]      ev_clr    = wr_evst ? hwdata[2:0] : 3'h0;

  always @* begin
    case (rate_r)
      2'd0:    tick_end = T0;
      2'd1:    tick_end = T1;
      2'd2:    tick_end = T2;
      default: tick_end = T3;
    endcase
  end

  // lowest index has the highest hardware priority
  always @* begin
    top_pri = {NSRC{1'b0}};
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (pending[i]) begin
        top_pri = {NSRC{1'b0}};
        top_pri[i] = 1'b1;
      end
    end
  end

  // key pins are asynchronous: two flops before any logic looks at them
  chrc_sync2 #(
    .WIDTH (4)
  ) key_sync_u (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (key_input_port),
    .q     (key_sync)
  );

  // ahb-lite slave: address phase captured for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
    end else if (hready) begin
      ap_valid_r <= hsel & htrans[1];
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr[7:0];
    end
  end

  // every transfer completes at once with an okay answer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read mux, decoded from the address phase
  always @* begin
    case (haddr[7:0])
      `CHRC_OFS_CTRL:     rd_nxt = {26'h0, serial_slave_r, 3'h0, rate_r};
      `CHRC_OFS_STATUS:   rd_nxt = {20'h0, mask_r, 5'h0, state_r};
      `CHRC_OFS_IRQ_STAT: rd_nxt = {29'h0, ev_stat_r};
      `CHRC_OFS_IRQ_MASK: rd_nxt = {29'h0, ev_mask_r};
      `CHRC_OFS_PORTCFG:  rd_nxt = {20'h0, key_dir_out, key_pulldown_en,
                                    adsel_r};
      `CHRC_OFS_TICK:     rd_nxt = {31'h0, tick_carry_flag};
      `CHRC_OFS_SOURCE:   rd_nxt = {{(16-NSRC){1'b0}}, enable_r,
                                    {(16-NSRC){1'b0}}, req_r};
      default:            rd_nxt = 32'h0000_0000;
    endcase
  end

  // registered so the data stands through the whole data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      hrdata <= rd_nxt;
    end
  end

  // configuration registers; pull-downs return only on power-on reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_r          <= `CHRC_RATE_RST;
      serial_slave_r  <= 1'b0;
      ev_mask_r       <= 3'h0;
      adsel_r         <= `CHRC_ADSEL_RST;
      key_pulldown_en <= `CHRC_PULLDN_RST;
      key_dir_out     <= 4'h0;
      enable_r        <= {NSRC{1'b0}};
    end else if (wr_en) begin
      case (ap_addr_r)
        `CHRC_OFS_CTRL: begin
          rate_r         <= hwdata[1:0];
          serial_slave_r <= hwdata[5];
        end
        `CHRC_OFS_IRQ_MASK: ev_mask_r <= hwdata[2:0];
        `CHRC_OFS_PORTCFG: begin
          adsel_r         <= hwdata[3:0];
          key_pulldown_en <= hwdata[7:4];
          key_dir_out     <= hwdata[11:8];
        end
        `CHRC_OFS_SOURCE: enable_r <= hwdata[16+NSRC-1:16];
        default: ;
      endcase
    end
  end

  // periodic tick carry; set wins over a software clear
  // counts are full length, so a short test never sees a carry
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r      <= 32'h0000_0000;
      tick_carry_flag <= 1'b0;
    end else begin
      if (tick_wrap) begin
        tick_cnt_r      <= 32'h0000_0000;
        tick_carry_flag <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'd1;
        if (wr_tick && hwdata[0])
          tick_carry_flag <= 1'b0;
      end
    end
  end

  // request flags: a clear is held one instruction before it lands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r      <= {NSRC{1'b0}};
      clr_pend_r <= {NSRC{1'b0}};
    end else begin
      // a clear waits for the next instruction, so halt right after it wakes
      if (wr_src)
        clr_pend_r <= clr_pend_r | hwdata[NSRC-1:0];
      else if (instr_done)
        clr_pend_r <= {NSRC{1'b0}};
      // a fresh request in the same cycle as a clear keeps the flag set
      req_r <= (req_r & ~req_clr & ~irq_ack_onehot) | source_request_flag;
    end
  end

  // halt sequencer: next state
  always @* begin
    state_nxt   = state_r;
    mask_nxt    = mask_r;
    cpu_en_nxt  = cpu_clk_en;
    ser_run_nxt = serial_master_run;
    vec_nxt     = 1'b0;
    ack_nxt     = {NSRC{1'b0}};
    if (sys_rst) begin
      // any reset ends halt, whatever the mask says
      state_nxt   = ST_RUN;
      mask_nxt    = 4'h0;
      cpu_en_nxt  = 1'b1;
      ser_run_nxt = 1'b1;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (wr_halt) begin
            state_nxt   = ST_HALT;
            mask_nxt    = hwdata[3:0];
            cpu_en_nxt  = 1'b0;
            ser_run_nxt = serial_slave_r;
          end else if (global_irq_on && |pending) begin
            state_nxt = ST_SERV;
            vec_nxt   = 1'b1;
            ack_nxt   = top_pri;
          end
        end
        ST_HALT: begin
          if (wake) begin
            cpu_en_nxt  = 1'b1;
            ser_run_nxt = 1'b1;
            mask_nxt    = 4'h0;
            if (wake_irq && global_irq_on) begin
              // an acknowledged wake goes straight to its vector
              state_nxt = ST_SERV;
              vec_nxt   = 1'b1;
              ack_nxt   = top_pri;
            end else begin
              state_nxt = ST_RUN;
            end
          end
        end
        ST_SERV: begin
          if (return_from_service)
            state_nxt = ST_RUN;
        end
        default: begin
          state_nxt   = ST_RUN;
          cpu_en_nxt  = 1'b1;
          ser_run_nxt = 1'b1;
        end
      endcase
    end
  end

  // halt sequencer: outputs straight from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r           <= ST_RUN;
      mask_r            <= 4'h0;
      cpu_clk_en        <= 1'b1;
      periph_clk_en     <= 1'b1;
      serial_master_run <= 1'b1;
      irq_vector_req    <= 1'b0;
      irq_ack_onehot    <= {NSRC{1'b0}};
    end else begin
      state_r           <= state_nxt;
      mask_r            <= mask_nxt;
      cpu_clk_en        <= cpu_en_nxt;
      periph_clk_en     <= 1'b1;
      serial_master_run <= ser_run_nxt;
      irq_vector_req    <= vec_nxt;
      irq_ack_onehot    <= ack_nxt;
    end
  end

  // event status: set wins over write-one-to-clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_stat_r <= 3'h0;
    end else begin
      ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
    end
  end

  // level interrupt, one clock behind the status it reflects
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_stat_r & ev_mask_r);
    end
  end
endmodule

// two-flop synchroniser for pins from outside the clock domain
module chrc_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;

  assign q = s2_r;

  // only the second flop is visible outside
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
endmodule

// *** core/chrc_map.vh ***
// address map, field positions and timing counts of the halt release block
`ifndef CHRC_MAP_VH
`define CHRC_MAP_VH
`define CHRC_OFS_CTRL      8'h00
`define CHRC_OFS_STATUS    8'h04
`define CHRC_OFS_IRQ_STAT  8'h08
`define CHRC_OFS_IRQ_MASK  8'h0C
`define CHRC_OFS_PORTCFG   8'h10
`define CHRC_OFS_TICK      8'h14
`define CHRC_OFS_SOURCE    8'h18
`define CHRC_OFS_HALTCMD   8'h1C
`define CHRC_H_PORT        0
`define CHRC_H_TICK        1
`define CHRC_H_IRQ         3
`define CHRC_EV_WAKE       0
`define CHRC_EV_TICK       1
`define CHRC_EV_RESET      2
`define CHRC_PULLDN_RST    4'hF
`define CHRC_ADSEL_RST     4'h0
`define CHRC_RATE_RST      2'h0
`define CHRC_CLK_HZ        10000000
`define CHRC_TICK_MS_0     100
`define CHRC_TICK_MS_1     50
`define CHRC_TICK_MS_2     20
`define CHRC_TICK_MS_3     10
`endif

// *** verif/chrc_asserts.sv ***
// port checks of the halt release controller
`timescale 1ns/10ps
module chrc_asserts #(
  parameter NSRC = 4
) (
  input wire            hclk,
  input wire            hresetn,
  input wire            hsel,
  input wire [31:0]     haddr,
  input wire [1:0]      htrans,
  input wire            hwrite,
  input wire [31:0]     hwdata,
  input wire            hready,
  input wire            hreadyout,
  input wire            hresp,
  input wire            watchdog_stack_reset,
  input wire            ce_reset,
  input wire            global_irq_on,
  input wire            cpu_clk_en,
  input wire            periph_clk_en,
  input wire            serial_master_run,
  input wire            irq_vector_req,
  input wire [NSRC-1:0] irq_ack_onehot,
  input wire            tick_carry_flag
);
  reg       hcmd_r;
  reg [3:0] msk_r;
  // shadow of the mask of the last halt command written while the cpu clock runs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcmd_r <= 1'b0;
      msk_r  <= 4'h0;
    end else begin
      hcmd_r <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h1C);
      if (hcmd_r & cpu_clk_en)
        msk_r <= hwdata[3:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  periph_run_a: assert property (periph_clk_en)
    else $error("peripheral clock stopped");
  halt_gate_a: assert property (hcmd_r && cpu_clk_en &&
    hwdata[3:0] == 4'h0 |-> ##[1:2] !cpu_clk_en)
    else $error("halt command did not stop the cpu");
  zero_mask_a: assert property (!cpu_clk_en && msk_r == 4'h0 &&
    !watchdog_stack_reset && !ce_reset |=> !cpu_clk_en)
    else $error("empty mask halt ended without reset");
  reset_wake_a: assert property (!cpu_clk_en &&
    (watchdog_stack_reset || ce_reset) |-> ##[1:2] cpu_clk_en)
    else $error("reset did not end halt");
  tick_wake_a: assert property (!cpu_clk_en && msk_r[1] &&
    $rose(tick_carry_flag) |-> ##[0:2] cpu_clk_en)
    else $error("tick carry did not end halt");
  serial_run_a: assert property (cpu_clk_en |-> serial_master_run)
    else $error("master serial stopped while running");
  vec_pulse_a: assert property (irq_vector_req |=> !irq_vector_req)
    else $error("vector request longer than one cycle");
  vec_global_a: assert property (irq_vector_req |->
    $past(global_irq_on))
    else $error("vector taken with interrupts off");
  ack_onehot_a: assert property ($onehot0(irq_ack_onehot))
    else $error("more than one acknowledge at once");
  cover property ($rose(cpu_clk_en));
  cover property (irq_vector_req);
  cover property (hcmd_r && cpu_clk_en);
endmodule

// *** verif/chrc_cpu_model.sv ***
// cpu core model: instruction beats and service routines
`timescale 1ns/10ps
module chrc_cpu_model (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       cpu_clk_en,
  input  wire       irq_vector_req,
  input  wire [7:0] svc_len,
  output reg        instr_done,
  output reg        return_from_service
);
  reg [1:0] ph_r;
  reg [7:0] svc_r;
  reg       busy_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 2'h0;
      svc_r <= 8'h00;
      busy_r <= 1'b0;
      instr_done <= 1'b0;
      return_from_service <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      // one instruction per four clocks, none while halted
      instr_done <= cpu_clk_en & (ph_r == 2'h3);
      return_from_service <= busy_r & (svc_r == 8'h00);
      if (irq_vector_req) begin
        busy_r <= 1'b1;
        svc_r <= svc_len;
      end else if (busy_r && svc_r != 8'h00)
        svc_r <= svc_r - 8'h01;
      else
        busy_r <= 1'b0;
    end
  end
endmodule

// *** verif/tb_cpu_halt_release_control.sv ***
// self-checking bench of the halt release controller
`timescale 1ns/10ps
module tb_cpu_halt_release_control;
  reg  hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, global_irq_on = 0;
  reg  watchdog_stack_reset = 0, ce_reset = 0;
  reg  [31:0] haddr = 0, hwdata = 0, rd;
  reg  [1:0]  htrans = 0;
  reg  [3:0]  key_input_port = 0, source_request_flag = 0;
  reg  [7:0]  svc_len = 0;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, instr_done, return_from_service;
  wire        cpu_clk_en, irq_vector_req, irq;
  wire        serial_master_run, tick_carry_flag;
  wire [3:0]  key_pulldown_en, key_dir_out;
  wire [3:0]  irq_ack_onehot;
  integer     error_cnt = 0, comparisons = 0, vec_cnt = 0, i, j, n;
  logic [3:0] acks[$], exp_q[$];
  chrc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .key_input_port(key_input_port),
    .watchdog_stack_reset(watchdog_stack_reset), .ce_reset(ce_reset),
    .instr_done(instr_done), .global_irq_on(global_irq_on),
    .return_from_service(return_from_service),
    .source_request_flag(source_request_flag), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(), .serial_master_run(serial_master_run),
    .irq_vector_req(irq_vector_req),
    .irq_ack_onehot(irq_ack_onehot), .tick_carry_flag(tick_carry_flag),
    .key_pulldown_en(key_pulldown_en), .key_dir_out(key_dir_out),
    .irq(irq));
  chrc_cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn),
    .cpu_clk_en(cpu_clk_en), .irq_vector_req(irq_vector_req),
    .svc_len(svc_len), .instr_done(instr_done),
    .return_from_service(return_from_service));
  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    if (irq_ack_onehot != 4'h0)
      acks.push_back(irq_ack_onehot);
    if (irq_vector_req === 1'b1)
      vec_cnt = vec_cnt + 1;
  end
  task finish_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // bounded wait for the cpu clock to reach a level
  task wt(input v);
    n = 0;
    while (cpu_clk_en !== v && n < 300) begin
      @(posedge hclk);
      n = n + 1;
    end
    chk(cpu_clk_en, v);
  endtask
  initial begin
    #(20000 * 100);
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial begin
    i = $urandom(58921);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 8'h04, 0);
    chk(rd, 32'h0000_0001);
    bus(0, 8'h10, 0);
    chk(rd, 32'h0000_00F0);
    chk(key_pulldown_en, 4'hF);
    chk(key_dir_out, 4'h0);
    chk(tick_carry_flag, 1'b0);
    chk(serial_master_run, 1'b1);
    bus(0, 8'h40, 0);
    chk(rd, 32'h0000_0000);
    for (j = 0; j < 2; j++) begin
      bus(1, 8'h00, j << 5);
      bus(1, 8'h1C, 0);
      repeat (40) @(posedge hclk);
      chk(cpu_clk_en, 1'b0);
      chk(serial_master_run, j[0]);
      bus(0, 8'h04, 0);
      chk(rd, 32'h0000_0002);
      if (j == 0) watchdog_stack_reset <= 1'b1;
      else ce_reset <= 1'b1;
      @(posedge hclk);
      watchdog_stack_reset <= 1'b0;
      ce_reset <= 1'b0;
      wt(1);
    end
    // a pin taken by the converter must not wake
    i = $urandom % 4;
    bus(1, 8'h10, 32'h0000_00F0 | (32'h1 << i));
    bus(1, 8'h1C, 1);
    key_input_port <= 4'h1 << i;
    repeat (30) @(posedge hclk);
    chk(cpu_clk_en, 1'b0);
    bus(0, 8'h04, 0);
    chk(rd, 32'h0000_0102);
    bus(1, 8'h10, 32'h0000_00F0);
    wt(1);
    key_input_port <= 4'h0;
    chk(vec_cnt, 0);
    bus(0, 8'h04, 0);
    chk(rd, 32'h0000_0001);
    bus(0, 8'h08, 0);
    chk(rd & 32'h1, 1);
    bus(1, 8'h0C, 1);
    repeat (2) @(posedge hclk);
    chk(irq, 1);
    bus(1, 8'h0C, 0);
    repeat (2) @(posedge hclk);
    chk(irq, 0);
    bus(1, 8'h0C, 1);
    bus(1, 8'h08, 7);
    repeat (2) @(posedge hclk);
    chk(irq, 0);
    j = $urandom % 4;
    source_request_flag <= 4'h1 << j;
    @(posedge hclk);
    source_request_flag <= 4'h0;
    bus(1, 8'h1C, 8);
    repeat (30) @(posedge hclk);
    chk(cpu_clk_en, 1'b0);
    bus(1, 8'h18, 32'h1 << (16 + j));
    wt(1);
    chk(vec_cnt, 0);
    bus(1, 8'h18, (32'h1 << (16 + j)) | (32'h1 << j));
    repeat (20) @(posedge hclk);
    bus(0, 8'h18, 0);
    chk(rd, 32'h1 << (16 + j));
    global_irq_on <= 1'b1;
    svc_len <= $urandom % 40;
    bus(1, 8'h18, 32'h000F_0000);
    acks.delete();
    i = $urandom % 15 + 1;
    for (j = 0; j < 4; j++) if (i[j]) exp_q.push_back(4'h1 << j);
    bus(1, 8'h1C, 4'hB);
    source_request_flag <= i[3:0];
    @(posedge hclk);
    source_request_flag <= 4'h0;
    n = 0;
    while (acks.size() < exp_q.size() && n < 1000) begin
      @(posedge hclk);
      n = n + 1;
    end
    wt(1);
    chk(acks.size(), exp_q.size());
    foreach (exp_q[k]) chk(acks[k], exp_q[k]);
    chk(vec_cnt, exp_q.size());
    bus(1, 8'h10, 32'h0000_0A50);
    @(posedge hclk);
    chk(key_dir_out, 4'hA);
    chk(key_pulldown_en, 4'h5);
    finish_test;
  end
endmodule
bind chrc_top chrc_asserts #(.NSRC(NSRC)) chk_u (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp),
  .watchdog_stack_reset(watchdog_stack_reset), .ce_reset(ce_reset),
  .global_irq_on(global_irq_on), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .serial_master_run(serial_master_run),
  .irq_vector_req(irq_vector_req), .irq_ack_onehot(irq_ack_onehot),
  .tick_carry_flag(tick_carry_flag));
